// ==== rtl/pcrs_map.svh ====
// register offsets, reset values and field layout of the program counter and return stack block
`ifndef PCRS_MAP_SVH
`define PCRS_MAP_SVH
`define PCRS_OFF_PCLOW      4'h0
`define PCRS_OFF_PCHLAT     4'h1
`define PCRS_OFF_PCULAT     4'h2
`define PCRS_OFF_TOSLOW     4'h3
`define PCRS_OFF_TOSHIGH    4'h4
`define PCRS_OFF_TOSUP      4'h5
`define PCRS_OFF_INDEX      4'h6
`define PCRS_OFF_FLAGS      4'h7
`define PCRS_OFF_PCVIEW     4'h8
`define PCRS_PC_W           21
`define PCRS_DEPTH          31
`define PCRS_PTR_W          5
`define PCRS_PTR_MAX        5'h1F
`define PCRS_FLAG_FULL_BIT  7
`define PCRS_FLAG_EMPTY_BIT 6
`define PCRS_PC_RST         21'h000000
`define PCRS_PTR_RST        5'h00
`define PCRS_PC_STEP        21'h000002
`endif

// ==== rtl/pcrs_pkg.sv ====
// types shared by the program counter and return stack block
`default_nettype none
package pcrs_pkg;
    typedef enum logic [3:0]
    {
        PCRS_OP_NONE    = 4'h0,
        PCRS_OP_NEXT    = 4'h1,
        PCRS_OP_JUMP    = 4'h2,
        PCRS_OP_CALL    = 4'h3,
        PCRS_OP_RETURN  = 4'h4,
        PCRS_OP_SWPUSH  = 4'h5,
        PCRS_OP_SWPOP   = 4'h6
    } pcrs_op_e;

    typedef struct packed
    {
        pcrs_op_e    op;
        logic [20:0] target;
    } pcrs_cmd_s;

    typedef struct packed
    {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } pcrs_bus_req_s;

    typedef enum logic [1:0]
    {
        PCRS_BUS_IDLE = 2'b00,
        PCRS_BUS_ACK  = 2'b01
    } pcrs_bus_state_e;
endpackage
`default_nettype wire

// ==== rtl/pcrs_stack_mem.sv ====
// return address storage: 31 flip-flop entries, one write port, one read port
`include "pcrs_map.svh"
`default_nettype none
module pcrs_stack_mem
    import pcrs_pkg::*;
#(
    parameter int DEPTH = `PCRS_DEPTH,
    parameter int PTR_W = `PCRS_PTR_W,
    parameter int PC_W  = `PCRS_PC_W
)
(
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire logic             wr_en_i,
    input  wire logic [PTR_W-1:0] wr_idx_i,
    input  wire logic [PC_W-1:0]  wr_data_i,
    input  wire logic [PTR_W-1:0] rd_idx_i,
    output logic      [PC_W-1:0]  rd_data_o
);
    logic [PC_W-1:0] entry_ff [1:DEPTH];

    // index zero has no entry behind it
    genvar g;
    generate
        for (g = 1; g <= DEPTH; g++)
        begin : g_entry
            always_ff @(posedge clk_i or negedge arst_n_i)
            begin
                if (!arst_n_i)
                    entry_ff[g] <= '0;
                else if (wr_en_i && (wr_idx_i == PTR_W'(g)))
                    entry_ff[g] <= wr_data_i;
            end
        end
    endgenerate

    always_comb
    begin
        rd_data_o = '0;
        if (rd_idx_i != '0 && int'(rd_idx_i) <= DEPTH)
            rd_data_o = entry_ff[rd_idx_i];
    end
endmodule
`default_nettype wire

// ==== rtl/pcrs_bus_slave.sv ====
// avalon-mm slave front end: one wait cycle, then answer
`include "pcrs_map.svh"
`default_nettype none
module pcrs_bus_slave
    import pcrs_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          arst_n_i,
    input  wire pcrs_bus_req_s req_i,
    output logic               accept_o,
    output logic               waitrequest_o
);
    typedef struct packed
    {
        pcrs_bus_state_e state;
    } pcrs_slv_s;

    pcrs_slv_s st_ff;
    pcrs_slv_s nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff.state)
            PCRS_BUS_IDLE:
            begin
                if (req_i.read || req_i.write)
                    nxt_st.state = PCRS_BUS_ACK;
            end
            PCRS_BUS_ACK:
            begin
                nxt_st.state = PCRS_BUS_IDLE;
            end
            default:
            begin
                nxt_st.state = PCRS_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            st_ff <= '{state: PCRS_BUS_IDLE};
        else
            st_ff <= nxt_st;
    end

    // accept on the ack cycle, where waitrequest is low
    assign accept_o      = (st_ff.state == PCRS_BUS_ACK) && (req_i.read || req_i.write);
    assign waitrequest_o = !(st_ff.state == PCRS_BUS_ACK);
endmodule
`default_nettype wire

// ==== rtl/pcrs_top.sv ====
// program counter with latched upper bytes and hardware return address stack
//
// The implementer's own choices: the address map and the Avalon-MM register port.
`include "pcrs_map.svh"
`default_nettype none
module pcrs_top
    import pcrs_pkg::*;
#(
    parameter int DEPTH = `PCRS_DEPTH,
    parameter int PTR_W = `PCRS_PTR_W,
    parameter int PC_W  = `PCRS_PC_W
)
(
    input  wire logic        CLK_I,
    input  wire logic        ARST_N_I,
    input  wire logic        POR_N_I,
    input  wire logic        FAULT_RESET_EN_I,
    input  wire pcrs_cmd_s   CMD_I,
    input  wire logic [3:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    output logic      [31:0] AVS_READDATA_O,
    output logic             AVS_WAITREQUEST_O,
    output logic      [20:0] PC_O,
    output logic             STACK_FAULT_RESET_O
);
    ////////////////////////////////////////////////////////////////////////////////////////
    typedef struct packed
    {
        logic [PC_W-1:0]  pc;
        logic [7:0]       high_latch;
        logic [4:0]       upper_latch;
        logic [PTR_W-1:0] index;
        logic             full_flag;
        logic             empty_flag;
        logic             fault_rst;
        logic [31:0]      rdata;
        logic             wait_n;
        logic             cfg_en;
    } pcrs_state_s;

    pcrs_state_s st_ff;
    pcrs_state_s nxt_st;

    logic             por_meta_ff;
    logic             por_sync_ff;
    logic             mem_wr_en;
    logic [PTR_W-1:0] mem_wr_idx;
    logic [PC_W-1:0]  mem_wr_data;
    logic [PC_W-1:0]  tos;
    logic             accept;
    logic             slave_wait;
    pcrs_bus_req_s    bus_req;
    logic             rd_take;

    ////////////////////////////////////////////////////////////////////////////////////////
    // power-on reset indication from outside, synchronised
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            por_meta_ff <= 1'b0;
            por_sync_ff <= 1'b0;
        end
        else
        begin
            por_meta_ff <= POR_N_I;
            por_sync_ff <= por_meta_ff;
        end
    end

    assign bus_req = '{address: AVS_ADDRESS_I, read: AVS_READ_I, write: AVS_WRITE_I,
                       writedata: AVS_WRITEDATA_I};

    // a read is served as it is first seen, so its data stand on the answer cycle
    assign rd_take = bus_req.read && slave_wait;

    pcrs_bus_slave u_slave
    (
        .clk_i         (CLK_I),
        .arst_n_i      (ARST_N_I),
        .req_i         (bus_req),
        .accept_o      (accept),
        .waitrequest_o (slave_wait)
    );

    pcrs_stack_mem #(.DEPTH(DEPTH), .PTR_W(PTR_W), .PC_W(PC_W)) u_mem
    (
        .clk_i     (CLK_I),
        .arst_n_i  (ARST_N_I),
        .wr_en_i   (mem_wr_en),
        .wr_idx_i  (mem_wr_idx),
        .wr_data_i (mem_wr_data),
        .rd_idx_i  (st_ff.index),
        .rd_data_o (tos)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // next state: core command first, bus access after
    always_comb
    begin
        logic [PC_W-1:0]  seq_pc;
        logic             do_push;
        logic             ovf_evt;
        logic             unf_evt;
        logic [7:0]       wb;
        seq_pc      = st_ff.pc + `PCRS_PC_STEP;
        do_push     = 1'b0;
        ovf_evt     = 1'b0;
        unf_evt     = 1'b0;
        wb          = bus_req.writedata[7:0];
        nxt_st      = st_ff;
        mem_wr_en   = 1'b0;
        mem_wr_idx  = st_ff.index;
        mem_wr_data = st_ff.pc;
        nxt_st.fault_rst = 1'b0;
        nxt_st.wait_n    = 1'b0;
        nxt_st.cfg_en    = FAULT_RESET_EN_I;

        ////////////////////////////////////////////////////////////////////////////////////
        // core command
        case (CMD_I.op)
            PCRS_OP_NEXT:
            begin
                nxt_st.pc = seq_pc;
            end
            PCRS_OP_JUMP:
            begin
                nxt_st.pc = {CMD_I.target[20:1], 1'b0};
            end
            PCRS_OP_CALL:
            begin
                // counter already points past the call
                do_push   = 1'b1;
                nxt_st.pc = {CMD_I.target[20:1], 1'b0};
            end
            PCRS_OP_SWPUSH:
            begin
                // counter stays, only the stack moves
                do_push = 1'b1;
            end
            PCRS_OP_RETURN:
            begin
                // pop on an empty stack
                if (st_ff.index == `PCRS_PTR_RST)
                begin
                    unf_evt           = 1'b1;
                    nxt_st.pc         = `PCRS_PC_RST;
                    nxt_st.empty_flag = 1'b1;
                    nxt_st.fault_rst  = st_ff.cfg_en;
                end
                else
                begin
                    nxt_st.pc    = {tos[20:1], 1'b0};
                    nxt_st.index = st_ff.index - 1'b1;
                end
            end
            PCRS_OP_SWPOP:
            begin
                if (st_ff.index != `PCRS_PTR_RST)
                begin
                    nxt_st.index = st_ff.index - 1'b1;
                end
            end
            default:
            begin
            end
        endcase

        ////////////////////////////////////////////////////////////////////////////////////
        // push side: below index 31 the pointer moves up and the new top entry is written in the same cycle
        if (do_push)
        begin
            mem_wr_en = 1'b1;
            if (st_ff.index == `PCRS_PTR_MAX)
            begin
                ovf_evt          = 1'b1;
                nxt_st.full_flag = 1'b1;
                if (st_ff.cfg_en)
                begin
                    mem_wr_en        = 1'b0;
                    nxt_st.fault_rst = 1'b1;
                    nxt_st.index     = `PCRS_PTR_RST;
                end
                else
                begin
                    mem_wr_idx = `PCRS_PTR_MAX;
                end
            end
            else
            begin
                mem_wr_idx   = st_ff.index + 1'b1;
                nxt_st.index = mem_wr_idx;
            end
        end

        ////////////////////////////////////////////////////////////////////////////////////
        // register read, served as the request is first seen
        if (rd_take)
        begin
            // unmapped words and unused bits read as zero
            nxt_st.rdata = '0;
            if (bus_req.address == `PCRS_OFF_PCLOW)
            begin
                nxt_st.rdata[7:0]  = st_ff.pc[7:0];
                nxt_st.high_latch  = st_ff.pc[15:8];
                nxt_st.upper_latch = st_ff.pc[20:16];
            end
            else if (bus_req.address == `PCRS_OFF_PCHLAT)
            begin
                nxt_st.rdata[7:0] = st_ff.high_latch;
            end
            else if (bus_req.address == `PCRS_OFF_PCULAT)
            begin
                nxt_st.rdata[4:0] = st_ff.upper_latch;
            end
            else if (bus_req.address == `PCRS_OFF_TOSLOW)
            begin
                nxt_st.rdata[7:0] = tos[7:0];
            end
            else if (bus_req.address == `PCRS_OFF_TOSHIGH)
            begin
                nxt_st.rdata[7:0] = tos[15:8];
            end
            else if (bus_req.address == `PCRS_OFF_TOSUP)
            begin
                nxt_st.rdata[4:0] = tos[20:16];
            end
            else if (bus_req.address == `PCRS_OFF_INDEX)
            begin
                nxt_st.rdata[4:0] = st_ff.index;
            end
            else if (bus_req.address == `PCRS_OFF_FLAGS)
            begin
                nxt_st.rdata[`PCRS_FLAG_FULL_BIT]  = st_ff.full_flag;
                nxt_st.rdata[`PCRS_FLAG_EMPTY_BIT] = st_ff.empty_flag;
            end
            else if (bus_req.address == `PCRS_OFF_PCVIEW)
            begin
                nxt_st.rdata[20:0] = st_ff.pc;
            end
        end

        ////////////////////////////////////////////////////////////////////////////////////
        // register write, taken on the answer cycle
        if (accept && bus_req.write)
        begin
            if (bus_req.address == `PCRS_OFF_PCLOW)
            begin
                nxt_st.pc = {st_ff.upper_latch, st_ff.high_latch, wb[7:1], 1'b0};
            end
            else if (bus_req.address == `PCRS_OFF_PCHLAT)
            begin
                nxt_st.high_latch = wb;
            end
            else if (bus_req.address == `PCRS_OFF_PCULAT)
            begin
                nxt_st.upper_latch = wb[4:0];
            end
            else if (bus_req.address == `PCRS_OFF_INDEX)
            begin
                nxt_st.index = wb[4:0];
            end
            else if (bus_req.address == `PCRS_OFF_FLAGS)
            begin
                // hardware set in the same cycle wins over a software clear
                nxt_st.full_flag  = wb[`PCRS_FLAG_FULL_BIT] | ovf_evt;
                nxt_st.empty_flag = wb[`PCRS_FLAG_EMPTY_BIT] | unf_evt;
            end
            else if (st_ff.index != `PCRS_PTR_RST && !mem_wr_en)
            begin
                // one byte, or the upper five bits, merged into the addressed entry
                mem_wr_idx  = st_ff.index;
                mem_wr_data = tos;
                if (bus_req.address == `PCRS_OFF_TOSLOW)
                begin
                    mem_wr_en         = 1'b1;
                    mem_wr_data[7:0]  = wb;
                end
                else if (bus_req.address == `PCRS_OFF_TOSHIGH)
                begin
                    mem_wr_en         = 1'b1;
                    mem_wr_data[15:8] = wb;
                end
                else if (bus_req.address == `PCRS_OFF_TOSUP)
                begin
                    mem_wr_en          = 1'b1;
                    mem_wr_data[20:16] = wb[4:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // either reset clears the pointer; the flags are cleared by both as well
    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            st_ff       <= '0;
            // enable reads as set during the asynchronous reset; the power-on clear then holds it low until the level is sampled
            st_ff.cfg_en <= 1'b1;
        end
        else if (!por_sync_ff)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops; waitrequest from the slave state register
    assign AVS_READDATA_O      = st_ff.rdata;
    assign AVS_WAITREQUEST_O   = slave_wait;
    assign PC_O                = st_ff.pc;
    assign STACK_FAULT_RESET_O = st_ff.fault_rst;
endmodule
`default_nettype wire

// ==== testbench/pcrs_top_monitor.sv ====
// concurrent checks on the ports of the program counter and return stack block
`default_nettype none
module pcrs_top_monitor
    import pcrs_pkg::*;
(
    input wire logic        CLK_I,
    input wire logic        ARST_N_I,
    input wire logic        POR_N_I,
    input wire logic        FAULT_RESET_EN_I,
    input wire pcrs_cmd_s   CMD_I,
    input wire logic [3:0]  AVS_ADDRESS_I,
    input wire logic        AVS_READ_I,
    input wire logic        AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic        AVS_WAITREQUEST_O,
    input wire logic [20:0] PC_O,
    input wire logic        STACK_FAULT_RESET_O
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I || !POR_N_I);
    ////////////////////////////////////////////////////////////////////////////////
    chk_pc_even: assert property (PC_O[0] == 1'b0)
        else $error("pc bit zero set");
    chk_next_step: assert property
        (CMD_I.op == PCRS_OP_NEXT && !AVS_WRITE_I |=> PC_O == $past(PC_O) + 21'h000002)
        else $error("sequential step wrong");
    chk_jump_load: assert property
        (CMD_I.op == PCRS_OP_JUMP && !AVS_WRITE_I |=> PC_O == {$past(CMD_I.target[20:1]), 1'b0})
        else $error("jump target not loaded");
    chk_call_load: assert property
        (CMD_I.op == PCRS_OP_CALL ##1 !STACK_FAULT_RESET_O |-> PC_O == {$past(CMD_I.target[20:1]), 1'b0})
        else $error("call target not loaded");
    chk_pc_hold: assert property
        (CMD_I.op inside {PCRS_OP_NONE, PCRS_OP_SWPUSH, PCRS_OP_SWPOP} && !AVS_WRITE_I |=> $stable(PC_O))
        else $error("pc moved without cause");
    chk_underflow_zero: assert property
        (CMD_I.op == PCRS_OP_RETURN ##1 STACK_FAULT_RESET_O |-> PC_O == 21'h000000)
        else $error("underflow pc not zero");
    chk_fault_pulse: assert property (STACK_FAULT_RESET_O |=> !STACK_FAULT_RESET_O)
        else $error("fault request longer than one cycle");
    chk_fault_cause: assert property
        (STACK_FAULT_RESET_O |-> $past(CMD_I.op) inside {PCRS_OP_CALL, PCRS_OP_SWPUSH, PCRS_OP_RETURN})
        else $error("fault request without stack operation");
    chk_wait_idle: assert property (!AVS_READ_I && !AVS_WRITE_I |-> AVS_WAITREQUEST_O)
        else $error("waitrequest low while idle");
    chk_bus_answer: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("no answer after one wait cycle");
    chk_wait_pulse: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
        else $error("answer longer than one cycle");
    cov_call: cover property (CMD_I.op == PCRS_OP_CALL);
    cov_fault: cover property (STACK_FAULT_RESET_O);
    cov_read: cover property (AVS_READ_I && !AVS_WAITREQUEST_O);
endmodule
`default_nettype wire

// ==== testbench/pcrs_core_model.sv ====
// behavioural core decoder: issues one operation per call, then idles
`default_nettype none
module pcrs_core_model
    import pcrs_pkg::*;
(
    input  wire logic      clk_i,
    output var  pcrs_cmd_s cmd_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial cmd_o = '0;
    task automatic issue(input pcrs_op_e op, input logic [20:0] target);
        @(posedge clk_i);
        cmd_o <= '{op, target};
        @(posedge clk_i);
        cmd_o <= '{PCRS_OP_NONE, 21'h000000};
    endtask
endmodule
`default_nettype wire

// ==== testbench/program_counter_return_stack_tb_top.sv ====
// self-checking bench: core model, bus master tasks and reference model
`default_nettype none
module program_counter_return_stack_tb_top
    import pcrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic          clk = 1'b0;
    logic          arst_n = 1'b0;
    logic          por_n = 1'b1;
    logic          fault_en = 1'b0;
    pcrs_cmd_s     cmd;
    pcrs_bus_req_s req = '0;
    logic [31:0]   avs_readdata;
    logic          avs_waitrequest;
    logic [20:0]   pc_o;
    logic          fault_o;
    logic [31:0]   rdv;
    int            n_errors = 0;
    int            total_checks = 0;
    int            pc, ptr, hl, ul, full, emp, i;
    int            stk [32];
    always #2.5 clk = ~clk;
    pcrs_core_model u_pcrs_core_model (.clk_i(clk), .cmd_o(cmd));
    pcrs_top u_pcrs_top
    (
        .CLK_I(clk), .ARST_N_I(arst_n), .POR_N_I(por_n), .FAULT_RESET_EN_I(fault_en), .CMD_I(cmd),
        .AVS_ADDRESS_I(req.address), .AVS_READ_I(req.read), .AVS_WRITE_I(req.write),
        .AVS_WRITEDATA_I(req.writedata), .AVS_READDATA_O(avs_readdata), .AVS_WAITREQUEST_O(avs_waitrequest),
        .PC_O(pc_o), .STACK_FAULT_RESET_O(fault_o)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        req <= '{a, !wr, wr, d};
        @(posedge clk);
        for (n = 0; n < 50 && avs_waitrequest !== 1'b0; n++)
            @(posedge clk);
        if (n == 50)
        begin
            n_errors++;
            print_verdict();
        end
        rdv = avs_readdata;
        req <= '0;
        @(posedge clk);
    endtask
    function automatic int exp_rd(input int a);
        int t;
        t = (ptr != 0) ? stk[ptr] : 0;
        case (a)
            0: return pc & 8'hFF;
            1: return hl;
            2: return ul;
            3: return t & 8'hFF;
            4: return (t >> 8) & 8'hFF;
            5: return t >> 16;
            6: return ptr;
            7: return full * 128 + emp * 64;
            8: return pc;
            default: return 0;
        endcase
    endfunction
    task automatic rd(input int a);
        bus(1'b0, 4'(a), 32'h00000000);
        check($sformatf("reg %0d", a), rdv, 32'(exp_rd(a)));
        if (a == 0)
        begin
            hl = (pc >> 8) & 8'hFF;
            ul = pc >> 16;
        end
    endtask
    task automatic wr(input int a, input int d);
        bus(1'b1, 4'(a), 32'(d));
        d = d & 8'hFF;
        case (a)
            0: pc = ul * 65536 + hl * 256 + (d & 8'hFE);
            1: hl = d;
            2: ul = d & 5'h1F;
            3: if (ptr != 0) stk[ptr] = (stk[ptr] & 21'h1FFF00) | d;
            4: if (ptr != 0) stk[ptr] = (stk[ptr] & 21'h1F00FF) | (d << 8);
            5: if (ptr != 0) stk[ptr] = (stk[ptr] & 21'h00FFFF) | ((d & 5'h1F) << 16);
            6: ptr = d & 5'h1F;
            7: full = d >> 7;
            default: ;
        endcase
        if (a == 7) emp = (d >> 6) & 1;
    endtask
    task automatic push(output logic f);
        f = 1'b0;
        if (ptr == 31)
        begin
            full = 1;
            f = fault_en;
            if (fault_en) ptr = 0;
            else stk[31] = pc;
        end
        else
        begin
            ptr++;
            stk[ptr] = pc;
        end
    endtask
    task automatic op(input pcrs_op_e o, input int t);
        logic f;
        f = 1'b0;
        case (o)
            PCRS_OP_NEXT: pc = (pc + 2) & 21'h1FFFFF;
            PCRS_OP_JUMP: pc = t & 21'h1FFFFE;
            PCRS_OP_CALL:
            begin
                push(f);
                pc = t & 21'h1FFFFE;
            end
            PCRS_OP_SWPUSH: push(f);
            PCRS_OP_SWPOP: if (ptr != 0) ptr--;
            PCRS_OP_RETURN:
            begin
                f = (ptr == 0) & fault_en;
                emp = emp | (ptr == 0);
                pc = (ptr == 0) ? 0 : stk[ptr] & 21'h1FFFFE;
                if (ptr != 0) ptr--;
            end
            default: ;
        endcase
        u_pcrs_core_model.issue(o, 21'(t));
        @(negedge clk);
        check("fault request", fault_o, 32'(f));
        if (!f) check("pc", pc_o, 32'(pc));
    endtask
    task automatic reset_all(input logic por);
        @(posedge clk);
        if (por) por_n <= 1'b0;
        else arst_n <= 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        por_n <= 1'b1;
        repeat (3) @(posedge clk);
        {pc, ptr, hl, ul, full, emp} = '0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(11666));
        reset_all(1'b0);
        for (i = 0; i < 16; i++) rd(i);
        $display("test reset values done");
        repeat (3) op(PCRS_OP_NEXT, 0);
        op(PCRS_OP_JUMP, $urandom | 1);
        wr(1, $urandom);
        wr(2, $urandom);
        op(PCRS_OP_JUMP, $urandom);
        wr(0, $urandom);
        rd(8);
        op(PCRS_OP_JUMP, $urandom);
        for (i = 0; i < 3; i++) rd(i);
        $display("test program counter done");
        for (i = 0; i < 33; i++)
        begin
            op(PCRS_OP_CALL, $urandom);
            for (int a = 3; a < 8; a++) rd(a);
        end
        wr(7, 8'h80);
        rd(7);
        wr(7, 8'h00);
        rd(7);
        for (i = 0; i < 32; i++) op(PCRS_OP_RETURN, 0);
        for (i = 1; i < 8; i++) rd(i);
        $display("test call and return done");
        wr(3, 8'h55);
        rd(3);
        op(PCRS_OP_SWPUSH, 0);
        for (i = 3; i < 6; i++) wr(i, $urandom);
        for (i = 3; i < 7; i++) rd(i);
        op(PCRS_OP_SWPUSH, 0);
        op(PCRS_OP_SWPOP, 0);
        rd(6);
        op(PCRS_OP_RETURN, 0);
        wr(6, $urandom);
        rd(6);
        $display("test top of stack done");
        @(posedge clk);
        fault_en <= 1'b1;
        wr(6, 31);
        op(PCRS_OP_CALL, $urandom);
        rd(6);
        rd(7);
        reset_all(1'b0);
        op(PCRS_OP_RETURN, 0);
        rd(7);
        wr(7, 8'hC0);
        reset_all(1'b1);
        rd(7);
        $display("test fault and power-on done");
        print_verdict();
    end
endmodule
bind pcrs_top pcrs_top_monitor u_pcrs_top_monitor
(
    .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .POR_N_I(POR_N_I), .FAULT_RESET_EN_I(FAULT_RESET_EN_I),
    .CMD_I(CMD_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_READDATA_O(AVS_READDATA_O),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .PC_O(PC_O), .STACK_FAULT_RESET_O(STACK_FAULT_RESET_O)
);
`default_nettype wire
